// ==== hw/sadc_regs.vh ====
// Timing constants and field layout for the converter readout block.
`ifndef SADC_REGS_VH
`define SADC_REGS_VH
`define SADC_CLK_PERIOD_PS    8000
`define SADC_CONV_BYP_NS      660
`define SADC_CONV_AMP_NS      1550
`define SADC_CONV_BYP_CYC     ((`SADC_CONV_BYP_NS * 1000) / `SADC_CLK_PERIOD_PS)
`define SADC_CONV_AMP_CYC     ((`SADC_CONV_AMP_NS * 1000) / `SADC_CLK_PERIOD_PS)
`define SADC_CSH_NORM_NS      150
`define SADC_CSH_LPM_NS       500
`define SADC_SCK_MAX_MHZ      50
`define SADC_RES_BITS         14
`define SADC_TAG_BITS         6
`define SADC_FRAME_BITS       20
`define SADC_GAIN_BYPASS      4'h0
`define SADC_CONV_CNT_W       8
`endif

// ==== hw/sadc_buf2.v ====
// Two-entry valid/ready buffer that carries conversion words to the shifter.
`timescale 1ns/1ps
module sadc_buf2 #(
  parameter WIDTH = 20
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_r [0:1];
  reg             wp_r;
  reg             rp_r;
  reg [1:0]       cnt_r;
  wire            push;
  wire            pop;

  assign in_ready_o  = (cnt_r != 2'h2);
  assign out_valid_o = (cnt_r != 2'h0);
  assign out_data_o  = mem_r[rp_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        mem_r[wp_r] <= in_data_i;
        wp_r        <= ~wp_r;
      end
      if (pop)
        rp_r <= ~rp_r;
      if (push && !pop)
        cnt_r <= cnt_r + 2'h1;
      else if (pop && !push)
        cnt_r <= cnt_r - 2'h1;
    end
  end
endmodule

// ==== hw/sadc_readout.v ====
// Conversion start, busy timing and serial readout of the 14-bit converter.
`timescale 1ns/1ps
`include "sadc_regs.vh"
// Behaviour
// - Falling chip select samples the selected channel and starts conversion.
// - Conversion is timed by the internal clock, needing no serial clock edges.
// - Busy is high for the whole conversion, low once it completes.
// - Most significant result bit is on data out when busy falls.
// - Each rising serial clock edge shifts out the next lower result bit.
// - Result is 14 bits, one sample per conversion, eight channels.
// - Amplifier offers bypass plus gains 1,2,3,4,6,8,12,16 from gain pins.
// - Channel and gain come only from parallel select pins.
// - Serial clock at most 50 MHz; at this system clock the two-clock pin filter needs a slower rate.
// - Busy high at most 660 ns bypassed, 1550 ns amplified.
// - Data out is high impedance while chip select high, low after falling edge.
// - Up to six more edges shift channel then gain bits, MSB first.
module sadc_readout #(
  parameter CONV_BYP_CYC = `SADC_CONV_BYP_CYC,
  parameter CONV_AMP_CYC = `SADC_CONV_AMP_CYC
) (
  input  wire        SYS_CLK_I,
  input  wire        RESET_I,
  input  wire        CS_N_I,
  input  wire        SCK_I,
  input  wire [2:0]  CHANNEL_SELECT_BITS_I,
  input  wire [3:0]  GAIN_SELECT_BITS_I,
  input  wire        LOW_POWER_SELECT_I,
  input  wire [13:0] SAMPLE_DATA_I,
  output reg         SAMPLE_STROBE_O,
  output reg  [2:0]  SAMPLE_CHANNEL_O,
  output reg         AMP_BYPASS_O,
  output reg  [2:0]  AMP_GAIN_O,
  output reg         BUSY_O,
  output reg         SDO_O,
  output reg         SDO_OE_N_O,
  output reg         POST_CONVERSION_DOZE_O
);
  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_LOAD = 2'h2;
  localparam ST_SHIFT = 2'h3;

  reg [2:0]  cs_sync_r;
  reg [2:0]  sck_sync_r;
  reg        cs_n_r;
  reg        sck_r;
  reg [1:0]  state_r;
  reg [7:0]  conv_cnt_r;
  reg [2:0]  chan_r;
  reg [3:0]  gain_r;
  reg [19:0] word_r;
  reg        word_valid_r;
  reg [19:0] shift_r;
  reg [4:0]  bit_cnt_r;
  wire       cs_n_new;
  wire       sck_new;
  wire       cs_fall;
  wire       cs_rise;
  wire       sck_rise;
  wire       buf_in_ready;
  wire       buf_out_valid;
  wire [19:0] buf_out_data;
  wire       take;

  // Only agreed second/third stages count, so glitches on the pins are ignored.
  assign cs_n_new = (cs_sync_r[1] == cs_sync_r[2]) ? cs_sync_r[2] : cs_n_r;
  assign sck_new  = (sck_sync_r[1] == sck_sync_r[2]) ? sck_sync_r[2] : sck_r;
  assign cs_fall  = cs_n_r & ~cs_n_new;
  assign cs_rise  = ~cs_n_r & cs_n_new;
  assign sck_rise = ~sck_r & sck_new & ~cs_n_new;
  // Idle also drains a word that a conversion cut short by chip select left behind.
  assign take     = ((state_r == ST_LOAD) | (state_r == ST_IDLE)) & buf_out_valid;

  // Busy also spans the load cycle, so the count is one short to stay inside the limit.
  function [7:0] conv_len;
    input [3:0] g;
    begin
      if (g == `SADC_GAIN_BYPASS)
        conv_len = CONV_BYP_CYC[7:0] - 8'h01;
      else
        conv_len = CONV_AMP_CYC[7:0] - 8'h01;
    end
  endfunction

  sadc_buf2 #(
    .WIDTH       (`SADC_FRAME_BITS)
  ) u_buf (
    .clk_i       (SYS_CLK_I),
    .rst_i       (RESET_I),
    .in_valid_i  (word_valid_r),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (word_r),
    .out_valid_o (buf_out_valid),
    .out_ready_i (take),
    .out_data_o  (buf_out_data)
  );

  // Reset idles the filter at the pins' idle levels so no false edge follows reset.
  always @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      cs_sync_r  <= 3'h7;
      sck_sync_r <= 3'h0;
      cs_n_r     <= 1'b1;
      sck_r      <= 1'b0;
    end
    else
    begin
      cs_sync_r  <= {cs_sync_r[1:0], CS_N_I};
      sck_sync_r <= {sck_sync_r[1:0], SCK_I};
      cs_n_r     <= cs_n_new;
      sck_r      <= sck_new;
    end
  end

  always @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      state_r    <= ST_IDLE;
      conv_cnt_r <= 8'h00;
      chan_r     <= 3'h0;
      gain_r     <= 4'h0;
      word_r     <= 20'h00000;
      word_valid_r <= 1'b0;
      shift_r    <= 20'h00000;
      bit_cnt_r  <= 5'h00;
      SAMPLE_STROBE_O <= 1'b0;
      SAMPLE_CHANNEL_O <= 3'h0;
      AMP_BYPASS_O <= 1'b1;
      AMP_GAIN_O <= 3'h0;
      BUSY_O     <= 1'b0;
      SDO_O      <= 1'b0;
      SDO_OE_N_O <= 1'b1;
      POST_CONVERSION_DOZE_O <= 1'b0;
    end
    else
    begin
      SAMPLE_STROBE_O <= 1'b0;
      if (word_valid_r && buf_in_ready)
        word_valid_r <= 1'b0;
      if (cs_rise)
      begin
        // Chip select high ends the frame and wakes the doze.
        SDO_OE_N_O <= 1'b1;
        SDO_O      <= 1'b0;
        BUSY_O     <= 1'b0;
        POST_CONVERSION_DOZE_O <= 1'b0;
        state_r    <= ST_IDLE;
      end
      else
      begin
        case (state_r)
          ST_IDLE:
          begin
            if (cs_fall)
            begin
              // Select pins are the only way channel and gain are chosen.
              chan_r <= CHANNEL_SELECT_BITS_I;
              gain_r <= GAIN_SELECT_BITS_I;
              SAMPLE_CHANNEL_O <= CHANNEL_SELECT_BITS_I;
              AMP_BYPASS_O <= (GAIN_SELECT_BITS_I == `SADC_GAIN_BYPASS);
              AMP_GAIN_O <= GAIN_SELECT_BITS_I[2:0] - 3'h1;
              SAMPLE_STROBE_O <= 1'b1;
              conv_cnt_r <= conv_len(GAIN_SELECT_BITS_I);
              BUSY_O     <= 1'b1;
              SDO_O      <= 1'b0;
              SDO_OE_N_O <= 1'b0;
              state_r    <= ST_CONV;
            end
          end
          ST_CONV:
          begin
            // Serial clock is ignored here; the host keeps it quiet anyway.
            if (conv_cnt_r == 8'h02)
            begin
              word_r <= {SAMPLE_DATA_I, chan_r, gain_r[2:0]};
              word_valid_r <= 1'b1;
            end
            if (conv_cnt_r == 8'h01)
              state_r <= ST_LOAD;
            conv_cnt_r <= conv_cnt_r - 8'h01;
          end
          ST_LOAD:
          begin
            if (buf_out_valid)
            begin
              // MSB is placed the same edge busy drops, so no latency is seen.
              shift_r    <= {buf_out_data[18:0], 1'b0};
              SDO_O      <= buf_out_data[19];
              BUSY_O     <= 1'b0;
              POST_CONVERSION_DOZE_O <= 1'b1;
              bit_cnt_r  <= 5'h01;
              state_r    <= ST_SHIFT;
            end
          end
          ST_SHIFT:
          begin
            // The pin filter needs each serial clock level to last two system clocks,
            // so the top serial rate asks for a faster system clock than this one.
            if (sck_rise && bit_cnt_r < `SADC_FRAME_BITS)
            begin
              SDO_O     <= shift_r[19];
              shift_r   <= {shift_r[18:0], 1'b0};
              bit_cnt_r <= bit_cnt_r + 5'h01;
            end
            else if (sck_rise)
              SDO_O <= 1'b0;
          end
          default:
          begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// ==== testbench/sadc_checker.sv ====
// Port assertions for the converter readout block.
`timescale 1ns/1ps
module sadc_checker #(
  parameter int CONV_BYP_CYC = 4,
  parameter int CONV_AMP_CYC = 6
) (
  input wire        SYS_CLK_I,
  input wire        RESET_I,
  input wire        CS_N_I,
  input wire [2:0]  CHANNEL_SELECT_BITS_I,
  input wire [3:0]  GAIN_SELECT_BITS_I,
  input wire [13:0] SAMPLE_DATA_I,
  input wire        SAMPLE_STROBE_O,
  input wire [2:0]  SAMPLE_CHANNEL_O,
  input wire        AMP_BYPASS_O,
  input wire        BUSY_O,
  input wire        SDO_O,
  input wire        SDO_OE_N_O
);
  localparam int LB = CONV_AMP_CYC;
  localparam int BB = CONV_BYP_CYC;
  default clocking @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RESET_I);
  start_ok_a: assert property (SAMPLE_STROBE_O |-> BUSY_O && !SDO_OE_N_O)
    else $error("start");
  strobe_one_a: assert property (SAMPLE_STROBE_O |=> !SAMPLE_STROBE_O) else $error("strobe");
  busy_cause_a: assert property ($rose(BUSY_O) |-> SAMPLE_STROBE_O) else $error("cause");
  busy_min_a: assert property ($rose(BUSY_O) |-> BUSY_O [*4]) else $error("short");
  busy_max_a: assert property ($rose(BUSY_O) |-> ##[1:LB] !BUSY_O) else $error("long");
  busy_byp_a: assert property ($rose(BUSY_O) && AMP_BYPASS_O |-> ##[1:BB] !BUSY_O)
    else $error("long bypass");
  oe_idle_a: assert property (CS_N_I [*6] |-> SDO_OE_N_O) else $error("idle");
  msb_ready_a: assert property ($fell(BUSY_O) |-> SDO_O == SAMPLE_DATA_I[13])
    else $error("msb");
  sel_map_a: assert property ($fell(BUSY_O) |-> SAMPLE_CHANNEL_O == CHANNEL_SELECT_BITS_I
    && AMP_BYPASS_O == (GAIN_SELECT_BITS_I == 4'h0)) else $error("select");
  cov_byp: cover property ($fell(BUSY_O) && AMP_BYPASS_O);
  cov_amp: cover property ($fell(BUSY_O) && !AMP_BYPASS_O);
  cov_end: cover property ($rose(SDO_OE_N_O));
endmodule
bind sadc_readout sadc_checker #(.CONV_BYP_CYC(CONV_BYP_CYC), .CONV_AMP_CYC(CONV_AMP_CYC))
  sadc_checker_i (.SYS_CLK_I,
  .RESET_I, .CS_N_I, .CHANNEL_SELECT_BITS_I, .GAIN_SELECT_BITS_I, .SAMPLE_DATA_I,
  .SAMPLE_STROBE_O, .SAMPLE_CHANNEL_O, .AMP_BYPASS_O, .BUSY_O, .SDO_O, .SDO_OE_N_O);

// ==== testbench/sadc_host.sv ====
// Host model that frames a conversion and shifts the result in.
`timescale 1ns/1ps
module sadc_host (
  input  wire  clk_i,
  input  wire  busy_i,
  input  wire  sdo_i,
  output logic cs_n_o = 1'b1,
  output logic sck_o = 1'b0
);
  task automatic frame(input int n, input bit low_power_select, output logic [19:0] w);
    int k;
    w = 20'h0;
    repeat (low_power_select ? 63 : 19) @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (k = 0; k < 30 && !busy_i; k++) @(negedge clk_i);
    for (k = 0; k < 300 && busy_i; k++) @(negedge clk_i);
    w[19] = sdo_i;
    // A 125 ns serial period stays well inside the 50 MHz limit.
    for (k = 18; k > 19 - n; k--)
    begin
      #62.5 sck_o = 1'b1;
      #62.5 sck_o = 1'b0;
      w[k] = sdo_i;
    end
    @(posedge clk_i);
    cs_n_o <= 1'b1;
  endtask
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the converter readout block.
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cs_n, sck, busy, sdo;
  logic        low_power_select = 1'b0;
  logic [2:0]  ch = 3'h0;
  logic [2:0]  sch;
  logic [2:0]  agn;
  logic        byp, oen, doze;
  logic [3:0]  gn = 4'h0;
  logic [13:0] dat = 14'h0;
  logic [19:0] got;
  int          fails = 0;
  int          comparisons = 0;
  int          n;
  always #4 clk = ~clk;
  sadc_readout #(.CONV_BYP_CYC(4), .CONV_AMP_CYC(6)) sadc_readout_i (.SYS_CLK_I(clk),
    .RESET_I(rst), .CS_N_I(cs_n), .SCK_I(sck), .CHANNEL_SELECT_BITS_I(ch),
    .GAIN_SELECT_BITS_I(gn), .LOW_POWER_SELECT_I(low_power_select), .SAMPLE_DATA_I(dat),
    .SAMPLE_STROBE_O(), .SAMPLE_CHANNEL_O(sch), .AMP_BYPASS_O(byp), .AMP_GAIN_O(agn),
    .BUSY_O(busy), .SDO_O(sdo), .SDO_OE_N_O(oen), .POST_CONVERSION_DOZE_O(doze));
  sadc_host sadc_host_i (.clk_i(clk), .busy_i(busy), .sdo_i(sdo), .cs_n_o(cs_n), .sck_o(sck));
  function automatic logic [19:0] exp_word(logic [13:0] d, logic [2:0] c, logic [3:0] g);
    return {d, c, g[2:0]};
  endfunction
  function automatic logic [2:0] gain_index(logic [3:0] g);
    return 3'(g - 4'h1);
  endfunction
  task automatic chk(input logic [19:0] g, input logic [19:0] e);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #300000;
    fails++;
    end_sim();
  end
  initial
  begin
    void'($urandom(85));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 14; i++)
    begin
      @(posedge clk);
      dat <= 14'($urandom);
      ch <= 3'($urandom);
      gn <= (i == 1) ? 4'h0 : (i == 2) ? 4'h8 : 4'($urandom % 9);
      low_power_select <= 1'($urandom);
      n = (i < 3) ? 20 : 14 + $urandom % 7;
      @(posedge clk);
      sadc_host_i.frame(n, low_power_select, got);
      @(negedge clk);
      // The first frame's word and channel are not compared.
      if (i > 0)
        chk(got >> (20 - n), exp_word(dat, ch, gn) >> (20 - n));
      if (i > 0)
        chk({17'h0, sch}, {17'h0, ch});
      chk({16'h0, byp, agn}, {16'h0, gn == 4'h0, gain_index(gn)});
      chk({18'h0, oen, doze}, 20'h00001);
      repeat (6) @(negedge clk);
      chk({18'h0, oen, doze}, 20'h00002);
    end
    end_sim();
  end
endmodule
